// ---- asdm_pkg.sv ----
// Package of constants and carrier types for the angle sensor diagnostics block
package asdm_pkg;
  // Register bus geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  // Register indices
  localparam logic [3:0] REG_ANGLE = 4'h0;
  localparam logic [3:0] REG_CTRL = 4'h1;
  localparam logic [3:0] REG_REFANG = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_MASK = 4'h4;
  localparam logic [3:0] REG_RAW = 4'h5;
  // Angle word field layout
  localparam int ANGLE_W = 13;
  localparam int FLAG_INTERNAL_ERROR_FLAG_BIT = 13;
  // Control field positions
  localparam int CTRL_SPEED_BIT = 2;
  // Status / mask bit positions
  localparam int ST_INTERNAL = 0;
  localparam int ST_MAGNET = 1;
  localparam int ST_MEM_DET = 2;
  localparam int ST_MEM_COR = 3;
  localparam int ST_BATTERY = 4;
  localparam int ST_VLOW = 5;
  localparam int ST_W = 6;
  // Reset values
  localparam logic [15:0] REFANG_RST = 16'h0000;
  localparam logic [5:0] MASK_RST = 6'h00;
  // Watchdog: system clock 10 ns period, allow 1 us without an edge
  localparam int CLK_NS = 10;
  localparam int WDOG_NS = 1000;
  localparam int WDOG_CYC = WDOG_NS / CLK_NS;
  localparam int WDOG_W = 8;
  localparam int MEM_DEPTH = 4;

  // Raw status inputs from analog / memory sides
  typedef struct packed {
    logic fieldLow;
    logic memErrDet;
    logic memErrCor;
    logic batteryLost;
    logic supplyLow;
  } asdm_sense_t;

  // Register bus request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } asdm_bus_t;
endpackage

// ---- asdm_cfg_mem.sv ----
// Small nonvolatile configuration memory image with registered read
`timescale 1ns/1ns
module asdm_cfg_mem #(
  parameter int DEPTH = 4,
  parameter int WIDTH = 16,
  parameter logic [WIDTH*DEPTH-1:0] INIT = '0
) (
  input wire logic clock, // System clock
  input wire logic [$clog2(DEPTH)-1:0] rdAddr, // Read word index
  output logic [WIDTH-1:0] rdData // Registered read data
);
  logic [WIDTH-1:0] mem [DEPTH];

  // Image is constant here; programming happens outside this block
  generate
    for (genvar i = 0; i < DEPTH; i++) begin : g_init
      assign mem[i] = INIT[i*WIDTH +: WIDTH];
    end
  endgenerate

  // Registered read port
  always_ff @(posedge clock) begin
    rdData <= mem[rdAddr];
  end
endmodule // asdm_cfg_mem

// ---- asdm_diag.sv ----
// Angle sensor diagnostics, zero offset and speed-mode selection
`timescale 1ns/1ns
module asdm_diag
  import asdm_pkg::*;
#(
  parameter logic [63:0] CFG_INIT = 64'h0000_0000_0000_0004 // Word 0 bit 2: low-speed default
) (
  input wire logic clock, // 100 MHz system clock
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic sampleClk, // Sampling clock from the front end
  input wire logic [12:0] rawAngle, // Raw measured angle
  input wire asdm_pkg::asdm_sense_t sense, // Asynchronous condition inputs
  input wire asdm_pkg::asdm_bus_t bus, // Register bus request
  output logic [15:0] rdData, // Read data, cycle after read
  output logic lowSpeedMode, // High while low-speed mode selected
  output logic irq // Level interrupt
);
  import asdm_pkg::*;

  // Two-flop synchronisers for all foreign inputs
  logic [5:0] syncA_q;
  logic [5:0] syncB_q;
  logic [ANGLE_W-1:0] rawA_q;
  logic [ANGLE_W-1:0] rawB_q;
  always_ff @(posedge clock) begin
    syncA_q <= {sampleClk, sense.fieldLow, sense.memErrDet, sense.memErrCor,
                sense.batteryLost, sense.supplyLow};
    syncB_q <= syncA_q;
    rawA_q <= rawAngle;
    rawB_q <= rawA_q;
  end

  logic clkS;
  logic fieldLowS;
  logic memDetS;
  logic memCorS;
  logic battS;
  logic vlowS;
  assign clkS = syncB_q[5];
  assign fieldLowS = syncB_q[4];
  assign memDetS = syncB_q[3];
  assign memCorS = syncB_q[2];
  assign battS = syncB_q[1];
  assign vlowS = syncB_q[0];

  // Edge finder on the sampling clock
  logic clkPrev_q;
  logic clkRise;
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      clkPrev_q <= 1'b0;
    end else begin
      clkPrev_q <= clkS;
    end
  end
  assign clkRise = clkS & ~clkPrev_q;

  // Watchdog: a stalled sampling clock means the logic is not working
  logic [WDOG_W-1:0] wdog_q;
  logic wdogTrip;
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      wdog_q <= '0;
    end else if (clkRise) begin
      wdog_q <= '0;
    end else if (wdog_q != WDOG_W'(WDOG_CYC)) begin
      wdog_q <= wdog_q + WDOG_W'(1);
    end
  end
  assign wdogTrip = (wdog_q == WDOG_W'(WDOG_CYC));

  // Raw angle captured on each sample edge
  logic [ANGLE_W-1:0] rawHold_q;
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rawHold_q <= '0;
    end else if (clkRise) begin
      rawHold_q <= rawB_q;
    end
  end

  // Configuration memory, word 0 holds the default speed mode
  logic [15:0] cfgWord;
  asdm_cfg_mem #(
    .DEPTH(MEM_DEPTH),
    .WIDTH(16),
    .INIT(CFG_INIT)
  ) u_cfg (
    .clock(clock),
    .rdAddr(2'b00),
    .rdData(cfgWord)
  );

  // Power-up sequence: memory read data valid one cycle after reset release
  logic loadPending_q;
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      loadPending_q <= 1'b1;
    end else begin
      loadPending_q <= 1'b0;
    end
  end

  // Bus strobes decoded once
  function automatic logic hit(input asdm_bus_t b, input logic [3:0] a);
    return b.wr && (b.addr == a);
  endfunction

  // Control register: speed mode bit
  logic [15:0] ctrl_q;
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ctrl_q <= '0;
    end else if (loadPending_q) begin
      ctrl_q <= 16'h0000;
      ctrl_q[CTRL_SPEED_BIT] <= cfgWord[CTRL_SPEED_BIT];
    end else if (hit(bus, REG_CTRL)) begin
      ctrl_q <= 16'h0000;
      ctrl_q[CTRL_SPEED_BIT] <= bus.wdata[CTRL_SPEED_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      lowSpeedMode <= 1'b0;
    end else begin
      lowSpeedMode <= ctrl_q[CTRL_SPEED_BIT];
    end
  end

  // Reference angle, written by host during zero calibration
  logic [ANGLE_W-1:0] refAng_q;
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      refAng_q <= REFANG_RST[ANGLE_W-1:0];
    end else if (hit(bus, REG_REFANG)) begin
      refAng_q <= bus.wdata[ANGLE_W-1:0];
    end
  end

  // Output angle; 13-bit subtraction wraps modulo a full turn
  logic [ANGLE_W-1:0] angleOut;
  assign angleOut = rawHold_q - refAng_q;

  // Condition events
  logic [ST_W-1:0] event_v;
  always_comb begin
    event_v = '0;
    event_v[ST_INTERNAL] = wdogTrip;
    event_v[ST_MAGNET] = fieldLowS;
    event_v[ST_MEM_DET] = memDetS;
    event_v[ST_MEM_COR] = memCorS;
    event_v[ST_BATTERY] = battS;
    event_v[ST_VLOW] = vlowS;
  end

  // Sticky status, write one to clear; a new event beats the clear
  logic [ST_W-1:0] status_q;
  logic [ST_W-1:0] clr;
  assign clr = hit(bus, REG_STATUS) ? bus.wdata[ST_W-1:0] : '0;
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~clr) | event_v;
    end
  end

  // Interrupt mask
  logic [ST_W-1:0] mask_q;
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      mask_q <= MASK_RST;
    end else if (hit(bus, REG_MASK)) begin
      mask_q <= bus.wdata[ST_W-1:0];
    end
  end

  // Next interrupt level taken from next status so irq tracks a flop
  logic [ST_W-1:0] statusNext;
  assign statusNext = (status_q & ~clr) | event_v;
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(statusNext & mask_q);
    end
  end

  // Angle response word: angle, internal error, magnet, supply low
  logic [15:0] angleWord;
  assign angleWord = {status_q[ST_VLOW],
                      status_q[ST_MAGNET],
                      status_q[ST_INTERNAL],
                      angleOut};

  // Read mux; unmapped reads give zero
  logic [15:0] rdMux;
  always_comb begin
    case (bus.addr)
      REG_ANGLE: rdMux = angleWord;
      REG_CTRL: rdMux = ctrl_q;
      REG_REFANG: rdMux = {3'b000, refAng_q};
      REG_STATUS: rdMux = {10'h000, status_q};
      REG_MASK: rdMux = {10'h000, mask_q};
      REG_RAW: rdMux = {3'b000, rawHold_q};
      default: rdMux = 16'h0000;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rdData <= '0;
    end else if (bus.rd) begin
      rdData <= rdMux;
    end else begin
      rdData <= '0;
    end
  end
endmodule // asdm_diag

// ---- asdm_front_end.sv ----
// Front-end model: sampling clock and raw angle
`timescale 1ns/1ns
module asdm_front_end (
  input wire logic run, // Clock enable
  input wire logic [12:0] angleIn, // Angle to present
  output logic sampleClk, // 80 ns sampling clock
  output logic [12:0] rawAngle // Raw angle
);
  // Stands still while stopped, so the watchdog can starve
  initial begin
    sampleClk = 1'b0;
    forever #40 sampleClk = run & ~sampleClk;
  end
  assign rawAngle = angleIn;
endmodule // asdm_front_end

// ---- asdm_diag_properties.sv ----
// Checker of bus, mode and reset behaviour
`timescale 1ns/1ns
module asdm_diag_properties (
  input wire logic clock, // Clock
  input wire logic reset_n, // Reset
  input wire asdm_pkg::asdm_bus_t bus, // Bus request
  input wire logic [15:0] rdData, // Read data
  input wire logic lowSpeedMode, // Mode
  input wire logic irq // Interrupt
);
  import asdm_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  AST_RD_IDLE: assert property (!$past(bus.rd) |-> rdData == 16'h0000)
    else $error("read data outside slot");
  AST_SPEED_SET: assert property (bus.wr && bus.addr == REG_CTRL && bus.wdata[2] |-> ##2 lowSpeedMode)
    else $error("low-speed not entered");
  AST_SPEED_CLR: assert property (bus.wr && bus.addr == REG_CTRL && !bus.wdata[2] |-> ##2 !lowSpeedMode)
    else $error("high-speed not entered");
  AST_SPEED_HOLD: assert property (!$past(bus.wr, 2) && $past(reset_n, 4) |-> $stable(lowSpeedMode))
    else $error("mode moved without write");
  AST_RESET_OUT: assert property (disable iff (1'b0) !reset_n |=> !irq && !lowSpeedMode)
    else $error("outputs live in reset");
  AST_STATUS_WIDTH: assert property (bus.rd && bus.addr == REG_STATUS |=> rdData[15:6] == 10'h000)
    else $error("status high bits set");
  AST_CTRL_READBACK: assert property (bus.rd && bus.addr == REG_CTRL |=> rdData[2] == lowSpeedMode)
    else $error("control bit differs from mode");
  AST_REF_READBACK: assert property (bus.wr && bus.addr == REG_REFANG ##2 bus.rd && bus.addr == REG_REFANG
    |=> rdData[12:0] == $past(bus.wdata[12:0], 3))
    else $error("reference not kept");
endmodule // asdm_diag_properties
bind asdm_diag asdm_diag_properties u_asdm_diag_properties (.clock(clock), .reset_n(reset_n),
  .bus(bus), .rdData(rdData), .lowSpeedMode(lowSpeedMode), .irq(irq));

// ---- test_asdm_diag.sv ----
// Self-checking bench for the diagnostics block
`timescale 1ns/1ns
module test_asdm_diag;
  import asdm_pkg::*;
  logic clock, reset_n, run, sampleClk, lowSpeedMode, irq;
  logic [12:0] angleIn, rawAngle;
  logic [15:0] rdData;
  asdm_sense_t sense;
  asdm_bus_t bus;
  int mismatches, n_compared;
  asdm_front_end u_asdm_front_end (.run(run), .angleIn(angleIn), .sampleClk(sampleClk),
    .rawAngle(rawAngle));
  asdm_diag u_asdm_diag (.clock(clock), .reset_n(reset_n), .sampleClk(sampleClk),
    .rawAngle(rawAngle), .sense(sense), .bus(bus), .rdData(rdData),
    .lowSpeedMode(lowSpeedMode), .irq(irq));
  // 100 MHz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    n_compared++;
    if (exp !== got) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clock);
  endtask
  // One-cycle strobe, then an idle cycle so no signal is driven twice in a step
  task automatic wr(logic [3:0] a, logic [15:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    cyc(1);
    bus <= '0;
    cyc(1);
  endtask
  task automatic rd(logic [3:0] a, logic [15:0] exp, string what);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    cyc(1);
    bus <= '0;
    #1 check(what, exp, rdData);
    cyc(1);
  endtask
  task automatic sc_reset();
    reset_n <= 1'b0;
    cyc(6);
    reset_n <= 1'b1;
    cyc(3);
  endtask
  task automatic sc_speed();
    check("mode", 16'h0001, {15'h0, lowSpeedMode});
    rd(REG_CTRL, 16'h0004, "ctrl");
    wr(REG_CTRL, 16'h0000);
    cyc(1);
    check("mode", 16'h0000, {15'h0, lowSpeedMode});
    wr(REG_CTRL, 16'h0004);
    cyc(1);
    check("mode", 16'h0001, {15'h0, lowSpeedMode});
  endtask
  task automatic sc_offset();
    angleIn <= 13'h0010;
    cyc(40);
    rd(REG_ANGLE, 16'h0010, "angle");
    wr(REG_REFANG, 16'h0010);
    rd(REG_ANGLE, 16'h0000, "angle");
    wr(REG_REFANG, 16'h0020);
    rd(REG_REFANG, 16'h0020, "ref");
    rd(REG_ANGLE, 16'h1ff0, "angle");
    rd(REG_RAW, 16'h0010, "raw");
    rd(4'hf, 16'h0000, "unmapped");
  endtask
  // Each of the five sense conditions in turn: sticky status, unmasked irq, clear by writing one
  task automatic sc_sense();
    for (int k = 0; k < 5; k++) begin
      sense <= asdm_sense_t'(5'h01 << k);
      cyc(8);
      rd(REG_STATUS, 16'h0001 << (5 - k), "status");
      if (k == 0) rd(REG_ANGLE, 16'h9ff0, "angle");
      if (k == 4) rd(REG_ANGLE, 16'h5ff0, "angle");
      check("irq", 16'h0000, {15'h0, irq});
      wr(REG_MASK, 16'h0001 << (5 - k));
      cyc(2);
      check("irq", 16'h0001, {15'h0, irq});
      // Clear while the condition still stands: the event must win
      wr(REG_STATUS, 16'h003f);
      rd(REG_STATUS, 16'h0001 << (5 - k), "status");
      sense <= '0;
      cyc(8);
      wr(REG_STATUS, 16'h003f);
      cyc(2);
      check("irq", 16'h0000, {15'h0, irq});
    end
  endtask
  task automatic sc_wdog();
    run <= 1'b0;
    cyc(150);
    rd(REG_STATUS, 16'h0001, "status");
    rd(REG_ANGLE, 16'h3ff0, "angle");
    run <= 1'b1;
    wr(REG_CTRL, 16'h0000);
    sc_reset();
    check("mode", 16'h0001, {15'h0, lowSpeedMode});
    rd(REG_REFANG, 16'h0000, "ref");
    rd(REG_MASK, 16'h0000, "mask");
  endtask
  task automatic complete_run();
    $display("mismatches %0d n_compared %0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    reset_n = 1'b0;
    run = 1'b1;
    angleIn = '0;
    sense = '0;
    bus = '0;
    mismatches = 0;
    n_compared = 0;
    sc_reset();
    sc_speed();
    sc_offset();
    sc_sense();
    sc_wdog();
    complete_run();
  end
endmodule // test_asdm_diag
